// >>> design/clock_ctrl_pkg.sv
// Constants shared by the clock selection control block
package clock_ctrl_pkg;
  // ----------------------------------------
  // Register byte addresses
  // ----------------------------------------
  localparam logic [11:0] ADDR_PRIMARY = 12'h00c;
  localparam logic [11:0] ADDR_SECONDARY = 12'h010;
  localparam logic [11:0] ADDR_IFACE = 12'h014;
  localparam logic [11:0] ADDR_STATUS = 12'h018;
  // ----------------------------------------
  // Primary clock register fields
  // ----------------------------------------
  localparam int BYPASS_BIT = 7;
  localparam int ADC_DIV_BIT = 5;
  localparam int ALT_TIMING_BIT = 4;
  localparam int DIV_FIVE_BIT = 3;
  localparam int MULT_LSB = 0;
  localparam int MULT_W = 3;
  localparam logic [2:0] MULT_MAX_CODE = 3'h4;
  // ----------------------------------------
  // Secondary and interface register fields
  // ----------------------------------------
  localparam int AUX_ROUTE_BIT = 5;
  localparam int SLOW_BIT = 2;
  localparam int DUPLEX_BIT = 4;
  localparam int AUX_ENABLE_BIT = 2;
  // ----------------------------------------
  // Status register fields
  // ----------------------------------------
  localparam int ST_BYPASS_BIT = 7;
  localparam int ST_ADC_DIV_BIT = 5;
  localparam int ST_ALT_BIT = 4;
  localparam int ST_DIV_FIVE_BIT = 3;
  localparam int ST_PENDING_BIT = 2;
  localparam int ST_ROUTE_BIT = 1;
  localparam int ST_RUNNING_BIT = 0;
  // ----------------------------------------
  // Reset values and divide ratios
  // ----------------------------------------
  localparam logic [7:0] PRIMARY_RESET = 8'h00;
  localparam logic [7:0] SECONDARY_RESET = 8'h00;
  localparam logic [7:0] IFACE_RESET = 8'h10;
  localparam logic [2:0] RATIO_ONE = 3'h1;
  localparam logic [2:0] RATIO_ADC = 3'h2;
  localparam logic [2:0] RATIO_TX = 3'h5;
endpackage

// >>> design/pll_clock_select_control.sv
// Clock source selection, dividers and loop control with an APB register file
`timescale 1ns/100ps
`default_nettype none
module pll_clock_select_control (
  // Clock and reset
  input wire logic clk,
  input wire logic reset,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Loop output edge, one-cycle pulse per loop clock edge
  input wire logic loop_tick,
  // Normal signal of the second interface pin
  input wire logic aux_normal_signal,
  // Loop control
  output logic [2:0] loop_mult_code,
  output logic loop_slow,
  output logic loop_running,
  output logic [4:0] loop_ratio_num,
  output logic [2:0] loop_ratio_den,
  // Clock enables and pin
  output logic rx_clk_en,
  output logic adc_clk_en,
  output logic tx_clk_en,
  output logic second_interface_pin,
  // Mode levels
  output logic duplex_select,
  output logic bypass_active
);
  typedef struct packed {
    logic [7:0] primary;
    logic [7:0] secondary;
    logic [7:0] iface;
    logic act_bypass;
    logic act_adc_div2;
    logic act_alt;
    logic act_div_five;
    logic act_route;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic [2:0] mult_code;
    logic slow;
    logic running;
    logic [4:0] ratio_num;
    logic [2:0] ratio_den;
    logic rx_en;
    logic adc_en;
    logic tx_en;
    logic toggle;
    logic pin;
  } ctrl_state_t;

  ctrl_state_t s_reg;
  ctrl_state_t s_next;

  logic addr_hit;
  logic [7:0] rd_byte;
  logic [7:0] status_byte;
  logic loop_eff_tick;
  logic rx_src_tick;
  logic adc_tick;
  logic adc_zero;
  logic tx_tick;
  logic tx_zero;
  logic route_ok;
  logic pending;
  logic access;

  // ----------------------------------------
  // Source selection
  // ----------------------------------------
  // Reference clock is clk itself, so it ticks every cycle
  assign loop_eff_tick = s_reg.act_bypass ? 1'b1 : loop_tick;
  assign rx_src_tick = s_reg.act_alt ? loop_eff_tick : 1'b1;
  assign route_ok = s_reg.iface[clock_ctrl_pkg::AUX_ENABLE_BIT] | s_reg.iface[clock_ctrl_pkg::DUPLEX_BIT];
  assign pending = (s_reg.primary[clock_ctrl_pkg::BYPASS_BIT] != s_reg.act_bypass)
    || (s_reg.primary[clock_ctrl_pkg::ADC_DIV_BIT] != s_reg.act_adc_div2)
    || (s_reg.primary[clock_ctrl_pkg::ALT_TIMING_BIT] != s_reg.act_alt)
    || (s_reg.primary[clock_ctrl_pkg::DIV_FIVE_BIT] != s_reg.act_div_five)
    || (s_reg.secondary[clock_ctrl_pkg::AUX_ROUTE_BIT] != s_reg.act_route);

  // ----------------------------------------
  // Dividers
  // ----------------------------------------
  tick_divider #(
    .MAX_RATIO(2)
  ) u_adc_div (
    .clk(clk),
    .reset(reset),
    .tick(rx_src_tick),
    .ratio(s_reg.act_adc_div2 ? clock_ctrl_pkg::RATIO_ADC : clock_ctrl_pkg::RATIO_ONE),
    .out_tick(adc_tick),
    .at_zero(adc_zero)
  );

  tick_divider #(
    .MAX_RATIO(5)
  ) u_tx_div (
    .clk(clk),
    .reset(reset),
    .tick(loop_eff_tick),
    .ratio(s_reg.act_div_five ? clock_ctrl_pkg::RATIO_TX : clock_ctrl_pkg::RATIO_ONE),
    .out_tick(tx_tick),
    .at_zero(tx_zero)
  );

  // ----------------------------------------
  // Register decode
  // ----------------------------------------
  assign access = psel & penable & s_reg.pready;
  assign addr_hit = (paddr == clock_ctrl_pkg::ADDR_PRIMARY) || (paddr == clock_ctrl_pkg::ADDR_SECONDARY)
    || (paddr == clock_ctrl_pkg::ADDR_IFACE) || (paddr == clock_ctrl_pkg::ADDR_STATUS);
  assign status_byte = {s_reg.act_bypass, 1'b0, s_reg.act_adc_div2, s_reg.act_alt, s_reg.act_div_five,
    pending, s_reg.act_route & route_ok, s_reg.running};
  assign rd_byte = (paddr == clock_ctrl_pkg::ADDR_PRIMARY) ? s_reg.primary :
    (paddr == clock_ctrl_pkg::ADDR_SECONDARY) ? s_reg.secondary :
    (paddr == clock_ctrl_pkg::ADDR_IFACE) ? s_reg.iface :
    (paddr == clock_ctrl_pkg::ADDR_STATUS) ? status_byte : 8'h00;

  always_comb begin
    s_next = s_reg;
    // Answer registered in setup, so access phase always sees pready
    s_next.pready = psel & ~penable;
    s_next.pslverr = psel & ~penable & ~addr_hit;
    if (psel && !penable && !pwrite) begin
      s_next.prdata = {24'h000000, rd_byte};
    end
    if (access && pwrite && addr_hit) begin
      case (paddr)
        clock_ctrl_pkg::ADDR_PRIMARY: begin
          s_next.primary = pwdata[7:0];
          // Unused multiplier codes leave the field as it was
          if (pwdata[clock_ctrl_pkg::MULT_LSB +: clock_ctrl_pkg::MULT_W] > clock_ctrl_pkg::MULT_MAX_CODE) begin
            s_next.primary[clock_ctrl_pkg::MULT_LSB +: clock_ctrl_pkg::MULT_W] =
              s_reg.primary[clock_ctrl_pkg::MULT_LSB +: clock_ctrl_pkg::MULT_W];
          end
        end
        clock_ctrl_pkg::ADDR_SECONDARY: begin
          s_next.secondary = pwdata[7:0];
        end
        clock_ctrl_pkg::ADDR_IFACE: begin
          s_next.iface = pwdata[7:0];
        end
        default: begin
          s_next.iface = s_reg.iface;
        end
      endcase
    end
    // Switching only at a common boundary trades a short delay for clean clocks
    if (adc_zero && tx_zero) begin
      s_next.act_bypass = s_reg.primary[clock_ctrl_pkg::BYPASS_BIT];
      s_next.act_adc_div2 = s_reg.primary[clock_ctrl_pkg::ADC_DIV_BIT];
      s_next.act_alt = s_reg.primary[clock_ctrl_pkg::ALT_TIMING_BIT];
      s_next.act_div_five = s_reg.primary[clock_ctrl_pkg::DIV_FIVE_BIT];
      s_next.act_route = s_reg.secondary[clock_ctrl_pkg::AUX_ROUTE_BIT];
    end
    // Loop control follows the registers directly
    s_next.mult_code = s_reg.primary[clock_ctrl_pkg::MULT_LSB +: clock_ctrl_pkg::MULT_W];
    s_next.slow = s_reg.secondary[clock_ctrl_pkg::SLOW_BIT];
    s_next.running = 1'b1;
    s_next.ratio_num = 5'(5'h01 << s_reg.primary[clock_ctrl_pkg::MULT_LSB +: clock_ctrl_pkg::MULT_W]);
    s_next.ratio_den = s_reg.primary[clock_ctrl_pkg::DIV_FIVE_BIT] ? clock_ctrl_pkg::RATIO_TX :
      clock_ctrl_pkg::RATIO_ONE;
    s_next.rx_en = rx_src_tick;
    s_next.adc_en = adc_tick;
    s_next.tx_en = tx_tick;
    if (loop_eff_tick) begin
      s_next.toggle = ~s_reg.toggle;
    end
    s_next.pin = (s_reg.act_route && route_ok) ? s_next.toggle : aux_normal_signal;
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      s_reg <= '0;
      s_reg.primary <= clock_ctrl_pkg::PRIMARY_RESET;
      s_reg.secondary <= clock_ctrl_pkg::SECONDARY_RESET;
      s_reg.iface <= clock_ctrl_pkg::IFACE_RESET;
      s_reg.ratio_num <= 5'h01;
      s_reg.ratio_den <= clock_ctrl_pkg::RATIO_ONE;
    end else begin
      s_reg <= s_next;
    end
  end

  // ----------------------------------------
  // Outputs
  // ----------------------------------------
  assign prdata = s_reg.prdata;
  assign pready = s_reg.pready;
  assign pslverr = s_reg.pslverr;
  assign loop_mult_code = s_reg.mult_code;
  assign loop_slow = s_reg.slow;
  assign loop_running = s_reg.running;
  assign loop_ratio_num = s_reg.ratio_num;
  assign loop_ratio_den = s_reg.ratio_den;
  assign rx_clk_en = s_reg.rx_en;
  assign adc_clk_en = s_reg.adc_en;
  assign tx_clk_en = s_reg.tx_en;
  assign second_interface_pin = s_reg.pin;
  assign duplex_select = s_reg.iface[clock_ctrl_pkg::DUPLEX_BIT];
  assign bypass_active = s_reg.act_bypass;

  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  a_loop_keeps_running: assert property (@(posedge clk) disable iff (reset)
    s_reg.act_bypass && !s_reg.act_div_five |=> loop_running && tx_clk_en)
    else $error("loop stopped or bypass not taking every reference edge");

  a_adc_from_loop: assert property (@(posedge clk) disable iff (reset)
    s_reg.act_alt && !s_reg.act_bypass && !s_reg.act_adc_div2 && !loop_tick |=> !adc_clk_en)
    else $error("converter clock ticked without a loop edge");

  a_adc_halved: assert property (@(posedge clk) disable iff (reset)
    !s_reg.act_alt && s_reg.act_adc_div2 && adc_clk_en |=> !adc_clk_en)
    else $error("halved converter clock ticked twice in a row");

  a_rx_normal_ref: assert property (@(posedge clk) disable iff (reset)
    !$past(reset) && !s_reg.act_alt |=> rx_clk_en)
    else $error("receive clock missed a reference edge");

  a_tx_div_five: assert property (@(posedge clk) disable iff (reset)
    tx_clk_en && s_reg.act_div_five && s_reg.act_bypass |=> !tx_clk_en)
    else $error("divide by five produced adjacent transmit ticks");

  a_mult_unused_kept: assert property (@(posedge clk) disable iff (reset)
    access && pwrite && paddr == clock_ctrl_pkg::ADDR_PRIMARY && pwdata[2:0] > 3'h4
    |=> s_reg.primary[2:0] == $past(s_reg.primary[2:0]))
    else $error("unused multiplier code was stored");

  a_ratio_tracks: assert property (@(posedge clk) disable iff (reset)
    ##1 loop_ratio_num == 5'(5'h01 << $past(s_reg.primary[2:0]))
    && loop_ratio_den == ($past(s_reg.primary[3]) ? 3'h5 : 3'h1))
    else $error("effective loop ratio does not match the settings");

  a_aux_clock_out: assert property (@(posedge clk) disable iff (reset)
    s_reg.act_route && route_ok && loop_eff_tick && $past(s_reg.act_route && route_ok)
    |=> second_interface_pin != $past(second_interface_pin))
    else $error("second interface pin did not carry the loop clock");

  a_aux_normal_out: assert property (@(posedge clk) disable iff (reset)
    !(s_reg.act_route && route_ok) |=> second_interface_pin == $past(aux_normal_signal))
    else $error("second interface pin left its normal signal");

  a_slow_follows: assert property (@(posedge clk) disable iff (reset)
    access && pwrite && paddr == clock_ctrl_pkg::ADDR_SECONDARY |=> ##1 loop_slow == $past(pwdata[2], 2))
    else $error("slow loop control did not follow the register");

  a_duplex_reset: assert property (@(posedge clk) disable iff (reset)
    $past(reset) |-> duplex_select)
    else $error("duplex select not high after reset");

  a_switch_safe: assert property (@(posedge clk) disable iff (reset)
    $changed(s_reg.act_alt) || $changed(s_reg.act_adc_div2) || $changed(s_reg.act_div_five)
    || $changed(s_reg.act_bypass) |-> $past(adc_zero && tx_zero))
    else $error("clock selection changed away from a divider boundary");

  // ----------------------------------------
  // Rate, refusal and bus checks
  // ----------------------------------------
  a_running_always: assert property (@(posedge clk) disable iff (reset)
    !$past(reset) |-> loop_running)
    else $error("loop running flag dropped");

  a_bypass_rx_every: assert property (@(posedge clk) disable iff (reset)
    s_reg.act_bypass && s_reg.act_alt |=> rx_clk_en)
    else $error("bypassed loop path missed a reference edge");

  a_adc_ref_normal: assert property (@(posedge clk) disable iff (reset)
    !$past(reset) && !s_reg.act_alt && !s_reg.act_adc_div2 |=> adc_clk_en)
    else $error("converter clock missed a reference edge");

  a_adc_alt_loop: assert property (@(posedge clk) disable iff (reset)
    s_reg.act_alt && !s_reg.act_bypass && !s_reg.act_adc_div2 && loop_tick |=> adc_clk_en)
    else $error("converter clock missed a loop edge");

  a_adc_half_rate: assert property (@(posedge clk) disable iff (reset)
    !s_reg.act_alt && s_reg.act_adc_div2 && !adc_clk_en && $past(!s_reg.act_alt && s_reg.act_adc_div2)
    |=> adc_clk_en)
    else $error("halved converter clock skipped two reference edges");

  a_rx_alt_loop: assert property (@(posedge clk) disable iff (reset)
    s_reg.act_alt && !s_reg.act_bypass |=> rx_clk_en == $past(loop_tick))
    else $error("receive clock does not follow the loop edges");

  a_tx_undivided: assert property (@(posedge clk) disable iff (reset)
    !s_reg.act_div_five |=> tx_clk_en == $past(loop_eff_tick))
    else $error("undivided transmit clock does not follow the loop");

  a_tx_idle_loop: assert property (@(posedge clk) disable iff (reset)
    s_reg.act_div_five && !s_reg.act_bypass && !loop_tick |=> !tx_clk_en)
    else $error("divided transmit clock ticked without a loop edge");

  a_mult_in_range: assert property (@(posedge clk) disable iff (reset)
    loop_mult_code <= clock_ctrl_pkg::MULT_MAX_CODE)
    else $error("multiplier output holds an unused code");

  a_mult_code_stored: assert property (@(posedge clk) disable iff (reset)
    access && pwrite && paddr == clock_ctrl_pkg::ADDR_PRIMARY
    && pwdata[clock_ctrl_pkg::MULT_LSB +: clock_ctrl_pkg::MULT_W] <= clock_ctrl_pkg::MULT_MAX_CODE
    |=> s_reg.primary == $past(pwdata[7:0]))
    else $error("legal primary write was not stored");

  a_ratio_num_power: assert property (@(posedge clk) disable iff (reset)
    $onehot(loop_ratio_num))
    else $error("loop ratio numerator is not a power of two");

  a_ratio_den_legal: assert property (@(posedge clk) disable iff (reset)
    loop_ratio_den == clock_ctrl_pkg::RATIO_ONE || loop_ratio_den == clock_ctrl_pkg::RATIO_TX)
    else $error("loop ratio denominator is neither one nor five");

  a_aux_holds_level: assert property (@(posedge clk) disable iff (reset)
    s_reg.act_route && route_ok && !loop_eff_tick && $past(s_reg.act_route && route_ok)
    |=> $stable(second_interface_pin))
    else $error("second interface pin moved without a loop edge");

  a_slow_tracks: assert property (@(posedge clk) disable iff (reset)
    ##1 loop_slow == $past(s_reg.secondary[clock_ctrl_pkg::SLOW_BIT]))
    else $error("slow loop output does not copy its register bit");

  a_route_switch_safe: assert property (@(posedge clk) disable iff (reset)
    $changed(s_reg.act_route) |-> $past(adc_zero && tx_zero))
    else $error("pin routing changed away from a divider boundary");

  a_apply_at_boundary: assert property (@(posedge clk) disable iff (reset)
    adc_zero && tx_zero |=> s_reg.act_alt == $past(s_reg.primary[clock_ctrl_pkg::ALT_TIMING_BIT])
    && s_reg.act_div_five == $past(s_reg.primary[clock_ctrl_pkg::DIV_FIVE_BIT]))
    else $error("pending selection not applied at a divider boundary");

  a_pready_single: assert property (@(posedge clk) disable iff (reset)
    pready |=> !pready)
    else $error("ready stood for more than one cycle");

  a_err_with_ready: assert property (@(posedge clk) disable iff (reset)
    pslverr |-> pready)
    else $error("error response without ready");

  a_unmapped_ignored: assert property (@(posedge clk) disable iff (reset)
    access && pwrite && !addr_hit |=> $stable(s_reg.primary) && $stable(s_reg.secondary) && $stable(s_reg.iface))
    else $error("write to an unmapped address changed a register");
endmodule
`default_nettype wire

// >>> design/tick_divider.sv
// Divides a stream of one-cycle ticks by a small ratio
`timescale 1ns/100ps
`default_nettype none
module tick_divider #(
  parameter int MAX_RATIO = 5
) (
  // Clock and reset
  input wire logic clk,
  input wire logic reset,
  // Tick stream
  input wire logic tick,
  input wire logic [2:0] ratio,
  output logic out_tick,
  output logic at_zero
);
  if (MAX_RATIO < 1 || MAX_RATIO > 7) begin : g_check
    $error("tick_divider ratio out of range");
  end

  typedef struct packed {
    logic [2:0] count;
  } div_state_t;

  div_state_t s_reg;
  div_state_t s_next;
  logic [2:0] last;

  // Ratio zero behaves as ratio one
  assign last = (ratio == 3'h0) ? 3'h0 : 3'(ratio - 3'h1);
  assign out_tick = tick && (s_reg.count >= last);
  assign at_zero = (s_reg.count == 3'h0);

  always_comb begin
    s_next = s_reg;
    if (tick) begin
      s_next.count = (s_reg.count >= last) ? 3'h0 : 3'(s_reg.count + 3'h1);
    end
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      s_reg <= '0;
    end else begin
      s_reg <= s_next;
    end
  end

  a_ratio_in_range: assert property (@(posedge clk) disable iff (reset)
    int'(ratio) <= MAX_RATIO)
    else $error("divider asked for a ratio it was not built for");
endmodule
`default_nettype wire

// >>> verif/loop_edge_source.sv
// Far-side model: loop output edges and the pin's normal signal
`timescale 1ns/100ps
`default_nettype none
module loop_edge_source #(
  parameter int PERIOD = 2
) (
  // Clock and reset
  input wire logic clk,
  input wire logic reset,
  // Far-side outputs
  output logic loop_tick,
  output logic aux_normal_signal
);
  int count;
  // ----------------------------------------
  // Loop edges, one pulse every PERIOD cycles
  // ----------------------------------------
  always @(posedge clk or posedge reset) begin
    if (reset) begin
      count <= 0;
      loop_tick <= 1'b0;
      aux_normal_signal <= 1'b0;
    end else begin
      count <= (count == PERIOD - 1) ? 0 : count + 1;
      loop_tick <= (count == PERIOD - 1);
      // Changes every cycle so a stale copy never passes for a match
      aux_normal_signal <= ~aux_normal_signal;
    end
  end
endmodule
`default_nettype wire

// >>> verif/pll_clock_select_control_tb.sv
// Self-checking bench for the clock selection control block
`timescale 1ns/100ps
`default_nettype none
module pll_clock_select_control_tb;
  logic clk = 1'b0;
  logic reset = 1'b1;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h00000000;
  logic [31:0] prdata;
  logic [31:0] rd;
  logic pready, pslverr, err, loop_tick, aux_normal_signal, loop_slow, loop_running;
  logic rx_clk_en, adc_clk_en, tx_clk_en, second_interface_pin, duplex_select, bypass_active;
  logic [2:0] loop_mult_code;
  logic [2:0] loop_ratio_den;
  logic [4:0] loop_ratio_num;
  int errors = 0;
  int n_checks = 0;
  int cycles = 0;
  int rx_n, adc_n, tx_n, pin_n;
  logic [7:0] cfg [8] = '{8'h00, 8'h20, 8'h10, 8'h30, 8'h08, 8'h80, 8'h88, 8'h90};
  int exp_rx [8] = '{40, 40, 20, 20, 40, 40, 40, 40};
  int exp_adc [8] = '{40, 20, 20, 10, 40, 40, 40, 40};
  int exp_tx [8] = '{20, 20, 20, 20, 4, 40, 8, 40};
  logic [7:0] iface_val [3] = '{8'h10, 8'h00, 8'h04};
  int exp_pin [3] = '{20, 40, 20};

  pll_clock_select_control u_dut (
    .clk(clk),
    .reset(reset),
    .psel(psel),
    .penable(penable),
    .pwrite(pwrite),
    .paddr(paddr),
    .pwdata(pwdata),
    .prdata(prdata),
    .pready(pready),
    .pslverr(pslverr),
    .loop_tick(loop_tick),
    .aux_normal_signal(aux_normal_signal),
    .loop_mult_code(loop_mult_code),
    .loop_slow(loop_slow),
    .loop_running(loop_running),
    .loop_ratio_num(loop_ratio_num),
    .loop_ratio_den(loop_ratio_den),
    .rx_clk_en(rx_clk_en),
    .adc_clk_en(adc_clk_en),
    .tx_clk_en(tx_clk_en),
    .second_interface_pin(second_interface_pin),
    .duplex_select(duplex_select),
    .bypass_active(bypass_active)
  );
  loop_edge_source u_src (
    .clk(clk),
    .reset(reset),
    .loop_tick(loop_tick),
    .aux_normal_signal(aux_normal_signal)
  );

  // ----------------------------------------
  // Clock and hang guard
  // ----------------------------------------
  always #5 clk = ~clk;
  always @(posedge clk) begin
    cycles++;
    if (cycles == 20000) begin
      errors++;
      finish_test();
    end
  end

  // ----------------------------------------
  // Tasks
  // ----------------------------------------
  task automatic finish_test();
    if (errors == 0 && n_checks > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
    n_checks++;
    if (got !== exp) begin
      errors++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask
  // Idle cycle first, so no signal is driven twice in one time step
  task automatic apb(input logic wr, input logic [11:0] addr, input logic [7:0] data);
    @(posedge clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= addr;
    pwdata <= {24'h000000, data};
    @(posedge clk);
    penable <= 1'b1;
    // Ends on pready; only the bench timeout ends this wait if pready never rises
    do begin
      @(posedge clk);
    end while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic read_check(input string what, input logic [11:0] addr, input logic [7:0] exp, input logic exp_err);
    apb(1'b0, addr, 8'h00);
    check(what, {24'h000000, exp}, rd);
    check("pslverr", {31'h0, exp_err}, {31'h0, err});
  endtask
  task automatic settle();
    int guard;
    guard = 0;
    do begin
      apb(1'b0, clock_ctrl_pkg::ADDR_STATUS, 8'h00);
      guard++;
    end while (rd[clock_ctrl_pkg::ST_PENDING_BIT] !== 1'b0 && guard < 20);
    check("pending", 32'h0, {31'h0, rd[clock_ctrl_pkg::ST_PENDING_BIT]});
  endtask
  // Whole periods of every ratio fit in 40 cycles, so counts are exact
  task automatic count_window();
    logic last;
    rx_n = 0;
    adc_n = 0;
    tx_n = 0;
    pin_n = 0;
    @(negedge clk);
    last = second_interface_pin;
    repeat (40) begin
      @(negedge clk);
      if (rx_clk_en === 1'b1) rx_n++;
      if (adc_clk_en === 1'b1) adc_n++;
      if (tx_clk_en === 1'b1) tx_n++;
      if (second_interface_pin !== last) pin_n++;
      last = second_interface_pin;
    end
  endtask

  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    repeat (16) @(posedge clk);
    reset <= 1'b0;
    read_check("primary", clock_ctrl_pkg::ADDR_PRIMARY, 8'h00, 1'b0);
    read_check("secondary", clock_ctrl_pkg::ADDR_SECONDARY, 8'h00, 1'b0);
    read_check("iface", clock_ctrl_pkg::ADDR_IFACE, 8'h10, 1'b0);
    check("duplex", 32'h1, {31'h0, duplex_select});
    check("slow reset", 32'h0, {31'h0, loop_slow});
    read_check("unmapped", 12'h020, 8'h00, 1'b1);
    apb(1'b1, 12'h020, 8'hff);
    check("pslverr write", 32'h1, {31'h0, err});
    read_check("iface kept", clock_ctrl_pkg::ADDR_IFACE, 8'h10, 1'b0);
    for (int c = 0; c < 5; c++) begin
      apb(1'b1, clock_ctrl_pkg::ADDR_PRIMARY, 8'(c));
      settle();
      check("mult code", c, {29'h0, loop_mult_code});
      check("ratio num", 32'h1 << c, {27'h0, loop_ratio_num});
      check("ratio den", 32'h1, {29'h0, loop_ratio_den});
    end
    apb(1'b1, clock_ctrl_pkg::ADDR_PRIMARY, 8'h0d);
    settle();
    read_check("unused code", clock_ctrl_pkg::ADDR_PRIMARY, 8'h0c, 1'b0);
    check("ratio num", 32'h10, {27'h0, loop_ratio_num});
    check("ratio den", 32'h5, {29'h0, loop_ratio_den});
    for (int i = 0; i < 8; i++) begin
      apb(1'b1, clock_ctrl_pkg::ADDR_PRIMARY, cfg[i]);
      settle();
      count_window();
      check("rx rate", exp_rx[i], rx_n);
      check("adc rate", exp_adc[i], adc_n);
      check("tx rate", exp_tx[i], tx_n);
      check("bypass", {31'h0, cfg[i][7]}, {31'h0, bypass_active});
      check("running", 32'h1, {31'h0, loop_running});
    end
    apb(1'b1, clock_ctrl_pkg::ADDR_PRIMARY, 8'h00);
    apb(1'b1, clock_ctrl_pkg::ADDR_SECONDARY, 8'h24);
    settle();
    check("slow", 32'h1, {31'h0, loop_slow});
    for (int i = 0; i < 3; i++) begin
      apb(1'b1, clock_ctrl_pkg::ADDR_IFACE, iface_val[i]);
      settle();
      check("route", {31'h0, exp_pin[i] == 20}, {31'h0, rd[clock_ctrl_pkg::ST_ROUTE_BIT]});
      count_window();
      check("pin toggles", exp_pin[i], pin_n);
    end
    apb(1'b1, clock_ctrl_pkg::ADDR_STATUS, 8'hff);
    settle();
    check("status bypass", 32'h0, {31'h0, rd[clock_ctrl_pkg::ST_BYPASS_BIT]});
    read_check("status", clock_ctrl_pkg::ADDR_STATUS, 8'h03, 1'b0);
    // Second reset in mid-run must bring the defaults back
    reset <= 1'b1;
    repeat (2) @(posedge clk);
    reset <= 1'b0;
    read_check("iface again", clock_ctrl_pkg::ADDR_IFACE, 8'h10, 1'b0);
    check("duplex again", 32'h1, {31'h0, duplex_select});
    read_check("secondary again", clock_ctrl_pkg::ADDR_SECONDARY, 8'h00, 1'b0);
    check("slow again", 32'h0, {31'h0, loop_slow});
    check("running again", 32'h1, {31'h0, loop_running});
    finish_test();
  end
endmodule
`default_nettype wire
